// ===== src/acs_regs.svh
// register indices, reset values and scaling constants of the calibration sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// register indices; byte address is four times the index
`define ACS_IDX_MAIN_OFF0 6'h07
`define ACS_IDX_MAIN_OFF1 6'h08
`define ACS_IDX_MAIN_OFF2 6'h09
`define ACS_IDX_MAIN_GAIN0 6'h0a
`define ACS_IDX_MAIN_GAIN1 6'h0b
`define ACS_IDX_MAIN_GAIN2 6'h0c
`define ACS_IDX_AUX_OFF0 6'h17
`define ACS_IDX_AUX_OFF1 6'h18
`define ACS_IDX_AUX_GAIN0 6'h19
`define ACS_IDX_AUX_GAIN1 6'h1a
`define ACS_IDX_CMD 6'h20
`define ACS_IDX_STATUS 6'h21
`define ACS_IDX_CTRL 6'h22
`define ACS_IDX_RESULT 6'h23
// reset values
`define ACS_MAIN_GAIN_UNITY 24'h40_0000
`define ACS_AUX_GAIN_UNITY 16'h4000
// averaging depth as a power of two
`define ACS_AVG_LOG2 4
// gain scaling shifts and full-scale numerators (full scale times unity)
`define ACS_MAIN_SHIFT 22
`define ACS_AUX_SHIFT 14
`define ACS_MAIN_GAIN_NUM 54'h1F_FFFF_FFC0_0000
`define ACS_AUX_GAIN_NUM 38'h1F_FFFF_C000
// status field positions
`define ACS_STAT_BUSY 3
`define ACS_STAT_DRDYN 4
`endif

// ===== src/acs_pkg.sv
// types shared by the calibration sequencer modules
`default_nettype none
package acs_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_COLLECT = 2'b01,
    ACS_STORE = 2'b10,
    ACS_WAITDATA = 2'b11
  } acs_state_t;
  // calibration command codes
  typedef enum logic [2:0] {
    ACS_CMD_NONE = 3'b000,
    ACS_MAIN_OFFSET_SELF_CAL_CMD = 3'b001,
    ACS_MAIN_OFFSET_SYSTEM_CAL_CMD = 3'b010,
    ACS_AUX_OFFSET_SELF_CAL_CMD = 3'b011,
    ACS_AUX_OFFSET_SYSTEM_CAL_CMD = 3'b100,
    ACS_MAIN_GAIN_SYSTEM_CAL_CMD = 3'b101,
    ACS_AUX_GAIN_SYSTEM_CAL_CMD = 3'b110
  } acs_cmd_t;
  // one conversion word with its strobe
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } acs_sample_t;
  // averager state
  typedef struct packed {
    logic [7:0] cnt;
    logic signed [39:0] sum;
    logic done;
    logic [31:0] avg;
  } acs_acc_t;
  // sequencer state
  typedef struct packed {
    acs_state_t st;
    acs_cmd_t cmd;
    logic [23:0] mainGain;
    logic [15:0] auxGain;
    logic [23:0] mainOff;
    logic [15:0] auxOff;
    logic chop;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] result;
    logic [23:0] auxResult;
    logic drdyN;
  } acs_core_t;
endpackage
`default_nettype wire

// ===== src/acs_avg.sv
// averager: sums a power-of-two number of samples and outputs the mean
`include "acs_regs.svh"
`default_nettype none
module acs_avg #(
  parameter int LOG2N = `ACS_AVG_LOG2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire acs_pkg::acs_sample_t smp,
  output logic done,
  output logic [31:0] avg
);
  acs_pkg::acs_acc_t state, next_state;
  logic signed [39:0] sumNow;

  // ==========================================
  // accumulate and divide by shifting
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    sumNow = state.sum + 40'(signed'(smp.data));
    if (clear) begin
      next_state.cnt = 8'h00;
      next_state.sum = 40'h00_0000_0000;
    end else if (smp.valid) begin
      if (state.cnt == 8'((1 << LOG2N) - 1)) begin
        next_state.done = 1'b1;
        next_state.avg = 32'(sumNow >>> LOG2N);
        next_state.cnt = 8'h00;
        next_state.sum = 40'h00_0000_0000;
      end else begin
        next_state.cnt = state.cnt + 8'h01;
        next_state.sum = sumNow;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done = state.done;
  assign avg = state.avg;
endmodule
`default_nettype wire

// ===== src/acs_cal_seq.sv
// calibration sequencer: coefficient registers, calibration commands, output correction
// ==========================================
// Behaviour
// - main gain word is 24-bit unsigned, 400000h means unity, scales linearly
// - main gain bytes sit at indices 0Ah, 0Bh, 0Ch, low byte first
// - gain word equals factor times unity: 433333h is 1.05, 3CCCCCh is 0.95
// - aux gain word is 16-bit unsigned, unity 4000h, larger raises gain
// - aux gain bytes sit at indices 19h and 1Ah, low byte first
// - main offset self cal shorts inputs, averages 16, writes main offset
// - main offset system cal averages 16 conversions into main offset
// - chop mode disables offset subtraction on the main channel
// - aux offset self cal shorts aux inputs, averages 16, writes aux offset
// - aux offset system cal averages 16 readings into aux offset
// - main gain cal averages 16, maps input to full scale, writes gain
// - aux gain cal averages 16, maps input to full scale, writes aux gain
// - main cal drives ready high, low once new coefficient data exist
// - aux calibration end gives no ready indication; host waits instead
// - main calibration time follows data rate and filter setting
// - output is (filter minus offset) times gain over unity, clipped 32-bit
//
// Chosen here: the Avalon-MM slave port.
`include "acs_regs.svh"
`default_nettype none
module acs_cal_seq #(
  parameter int AVG_LOG2 = `ACS_AVG_LOG2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire acs_pkg::acs_sample_t mainSample,
  input wire acs_pkg::acs_sample_t auxSample,
  output logic dataReadyN,
  output logic mainShortInputs,
  output logic auxShortInputs,
  output logic calBusy,
  output logic [31:0] mainResult,
  output logic [23:0] auxResult
);
  acs_pkg::acs_core_t state, next_state;
  acs_pkg::acs_sample_t accIn;
  acs_pkg::acs_cmd_t newCmd;
  logic [5:0] idx;
  logic busWr, busRd, cmdGo, newMain, curMain, idle;
  logic accDone, mAvgPos, aAvgPos;
  logic [31:0] accAvg;
  logic [32:0] mOffAl;
  logic signed [32:0] mDiff;
  logic signed [57:0] mScaled;
  logic signed [24:0] aDiff;
  logic signed [41:0] aScaled;
  logic [31:0] mClip;
  logic [23:0] aClip;
  logic [53:0] mQuot;
  logic [37:0] aQuot;
  logic [23:0] mGainNew;
  logic [15:0] aGainNew;

  // commands that belong to the main channel
  function automatic logic isMain(input acs_pkg::acs_cmd_t c);
    return c == acs_pkg::ACS_MAIN_OFFSET_SELF_CAL_CMD
      || c == acs_pkg::ACS_MAIN_OFFSET_SYSTEM_CAL_CMD
      || c == acs_pkg::ACS_MAIN_GAIN_SYSTEM_CAL_CMD;
  endfunction

  // ==========================================
  // bus slave: one wait cycle, completion on the second edge
  assign idx = avs_address[7:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~state.ack;
  assign busWr = avs_write & state.ack & avs_byteenable[0];
  assign busRd = avs_read & ~state.ack;
  assign idle = state.st == acs_pkg::ACS_IDLE;
  assign newCmd = acs_pkg::acs_cmd_t'(avs_writedata[2:0]);
  assign cmdGo = busWr && idx == `ACS_IDX_CMD && idle
    && newCmd != acs_pkg::ACS_CMD_NONE && avs_writedata[2:0] != 3'b111;
  assign newMain = isMain(newCmd);
  assign curMain = isMain(state.cmd);

  // ==========================================
  // main correction path
  assign mOffAl = state.chop ? 33'h0_0000_0000 : {state.mainOff[23], state.mainOff, 8'h00};
  assign mDiff = $signed({mainSample.data[31], mainSample.data}) - $signed(mOffAl);
  assign mScaled = (mDiff * $signed({1'b0, state.mainGain})) >>> `ACS_MAIN_SHIFT;
  // saturate when the upper bits disagree with the sign
  assign mClip = (&mScaled[57:31] || ~|mScaled[57:31]) ? mScaled[31:0]
    : (mScaled[57] ? 32'h8000_0000 : 32'h7FFF_FFFF);

  // aux correction path, offset aligned to the 24-bit word
  assign aDiff = $signed({auxSample.data[23], auxSample.data[23:0]})
    - $signed({state.auxOff[15], state.auxOff, 8'h00});
  assign aScaled = (aDiff * $signed({1'b0, state.auxGain})) >>> `ACS_AUX_SHIFT;
  assign aClip = (&aScaled[41:23] || ~|aScaled[41:23]) ? aScaled[23:0]
    : (aScaled[41] ? 24'h80_0000 : 24'h7F_FFFF);

  // ==========================================
  // averager feed: raw data for offset, offset-corrected data for gain
  always_comb begin
    accIn.valid = 1'b0;
    accIn.data = mainSample.data;
    if (state.st == acs_pkg::ACS_COLLECT) begin
      if (curMain) begin
        accIn.valid = mainSample.valid;
        if (state.cmd == acs_pkg::ACS_MAIN_GAIN_SYSTEM_CAL_CMD) begin
          accIn.data = mDiff[31:0];
        end
      end else begin
        accIn.valid = auxSample.valid;
        if (state.cmd == acs_pkg::ACS_AUX_GAIN_SYSTEM_CAL_CMD) begin
          accIn.data = 32'(aDiff);
        end else begin
          accIn.data = 32'(signed'(auxSample.data[23:0]));
        end
      end
    end
  end

  acs_avg #(
    .LOG2N(AVG_LOG2)
  ) u_avg (
    .clk(clk),
    .nrst(nrst),
    .clear(cmdGo),
    .smp(accIn),
    .done(accDone),
    .avg(accAvg)
  );

  // full-scale gain: full-scale code times unity over the averaged input
  assign mAvgPos = !accAvg[31] && |accAvg;
  assign aAvgPos = !accAvg[31] && |accAvg;
  assign mQuot = `ACS_MAIN_GAIN_NUM / {22'h00_0000, (mAvgPos ? accAvg : 32'h0000_0001)};
  assign aQuot = `ACS_AUX_GAIN_NUM / {6'h00, (aAvgPos ? accAvg : 32'h0000_0001)};
  assign mGainNew = (!mAvgPos || |mQuot[53:24]) ? 24'hFF_FFFF : mQuot[23:0];
  assign aGainNew = (!aAvgPos || |aQuot[37:16]) ? 16'hFFFF : aQuot[15:0];

  // ==========================================
  // sequencer, register file and ready flag
  always_comb begin
    next_state = state;
    next_state.ack = (avs_read | avs_write) & ~state.ack;
    // register writes; coefficients locked while calibrating
    if (busWr && idle) begin
      if (idx == `ACS_IDX_MAIN_OFF0) begin
        next_state.mainOff[7:0] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_MAIN_OFF1) begin
        next_state.mainOff[15:8] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_MAIN_OFF2) begin
        next_state.mainOff[23:16] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_MAIN_GAIN0) begin
        next_state.mainGain[7:0] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_MAIN_GAIN1) begin
        next_state.mainGain[15:8] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_MAIN_GAIN2) begin
        next_state.mainGain[23:16] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_AUX_OFF0) begin
        next_state.auxOff[7:0] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_AUX_OFF1) begin
        next_state.auxOff[15:8] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_AUX_GAIN0) begin
        next_state.auxGain[7:0] = avs_writedata[7:0];
      end else if (idx == `ACS_IDX_AUX_GAIN1) begin
        next_state.auxGain[15:8] = avs_writedata[7:0];
      end
    end
    if (busWr && idx == `ACS_IDX_CTRL) begin
      next_state.chop = avs_writedata[0];
    end
    // register reads, latched at the first edge, one edge before completion
    if (busRd) begin
      next_state.rdata = 32'h0000_0000;
      if (idx == `ACS_IDX_MAIN_OFF0) begin
        next_state.rdata[7:0] = state.mainOff[7:0];
      end else if (idx == `ACS_IDX_MAIN_OFF1) begin
        next_state.rdata[7:0] = state.mainOff[15:8];
      end else if (idx == `ACS_IDX_MAIN_OFF2) begin
        next_state.rdata[7:0] = state.mainOff[23:16];
      end else if (idx == `ACS_IDX_MAIN_GAIN0) begin
        next_state.rdata[7:0] = state.mainGain[7:0];
      end else if (idx == `ACS_IDX_MAIN_GAIN1) begin
        next_state.rdata[7:0] = state.mainGain[15:8];
      end else if (idx == `ACS_IDX_MAIN_GAIN2) begin
        next_state.rdata[7:0] = state.mainGain[23:16];
      end else if (idx == `ACS_IDX_AUX_OFF0) begin
        next_state.rdata[7:0] = state.auxOff[7:0];
      end else if (idx == `ACS_IDX_AUX_OFF1) begin
        next_state.rdata[7:0] = state.auxOff[15:8];
      end else if (idx == `ACS_IDX_AUX_GAIN0) begin
        next_state.rdata[7:0] = state.auxGain[7:0];
      end else if (idx == `ACS_IDX_AUX_GAIN1) begin
        next_state.rdata[7:0] = state.auxGain[15:8];
      end else if (idx == `ACS_IDX_STATUS) begin
        next_state.rdata[2:0] = state.cmd;
        next_state.rdata[`ACS_STAT_BUSY] = !idle;
        next_state.rdata[`ACS_STAT_DRDYN] = state.drdyN;
      end else if (idx == `ACS_IDX_CTRL) begin
        next_state.rdata[0] = state.chop;
      end else if (idx == `ACS_IDX_RESULT) begin
        next_state.rdata = state.result;
      end
    end
    // reading the result clears ready; fresh data below wins
    if (avs_read && state.ack && idx == `ACS_IDX_RESULT) begin
      next_state.drdyN = 1'b1;
    end
    if (auxSample.valid) begin
      next_state.auxResult = aClip;
    end
    if (mainSample.valid) begin
      next_state.result = mClip;
      if (!(curMain && (state.st == acs_pkg::ACS_COLLECT
          || state.st == acs_pkg::ACS_STORE))) begin
        next_state.drdyN = 1'b0;
      end
    end
    // calibration steps
    case (state.st)
      acs_pkg::ACS_IDLE: begin
        if (cmdGo) begin
          next_state.cmd = newCmd;
          next_state.st = acs_pkg::ACS_COLLECT;
          if (newMain) begin
            next_state.drdyN = 1'b1;
          end
        end
      end
      acs_pkg::ACS_COLLECT: begin
        if (accDone) begin
          next_state.st = acs_pkg::ACS_STORE;
        end
      end
      acs_pkg::ACS_STORE: begin
        // single complete update of the target coefficient
        case (state.cmd)
          acs_pkg::ACS_MAIN_OFFSET_SELF_CAL_CMD: next_state.mainOff = accAvg[31:8];
          acs_pkg::ACS_MAIN_OFFSET_SYSTEM_CAL_CMD: next_state.mainOff = accAvg[31:8];
          acs_pkg::ACS_AUX_OFFSET_SELF_CAL_CMD: next_state.auxOff = accAvg[23:8];
          acs_pkg::ACS_AUX_OFFSET_SYSTEM_CAL_CMD: next_state.auxOff = accAvg[23:8];
          acs_pkg::ACS_MAIN_GAIN_SYSTEM_CAL_CMD: next_state.mainGain = mGainNew;
          acs_pkg::ACS_AUX_GAIN_SYSTEM_CAL_CMD: next_state.auxGain = aGainNew;
          default: next_state.st = acs_pkg::ACS_IDLE;
        endcase
        // aux completion leaves the ready flag alone
        next_state.st = curMain ? acs_pkg::ACS_WAITDATA : acs_pkg::ACS_IDLE;
      end
      acs_pkg::ACS_WAITDATA: begin
        if (mainSample.valid) begin
          next_state.st = acs_pkg::ACS_IDLE;
        end
      end
      default: next_state.st = acs_pkg::ACS_IDLE;
    endcase
  end

  // state register; coefficients reset to unity gain and zero offset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= '0;
      state.mainGain <= `ACS_MAIN_GAIN_UNITY;
      state.auxGain <= `ACS_AUX_GAIN_UNITY;
      state.drdyN <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign avs_readdata = state.rdata;
  assign dataReadyN = state.drdyN;
  assign calBusy = !idle;
  assign mainResult = state.result;
  assign auxResult = state.auxResult;
  assign mainShortInputs = state.st == acs_pkg::ACS_COLLECT
    && state.cmd == acs_pkg::ACS_MAIN_OFFSET_SELF_CAL_CMD;
  assign auxShortInputs = state.st == acs_pkg::ACS_COLLECT
    && state.cmd == acs_pkg::ACS_AUX_OFFSET_SELF_CAL_CMD;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence seqMainStart;
    cmdGo && newMain;
  endsequence
  sequence seqStore(acs_pkg::acs_cmd_t c);
    state.st == acs_pkg::ACS_STORE && state.cmd == c;
  endsequence

  AST_RESET_UNITY: assert property ($rose(nrst) |-> state.mainGain == 24'h40_0000
    && state.auxGain == 16'h4000) else $error("gain not unity after reset");
  AST_MAIN_CAL_READY_HIGH: assert property (seqMainStart |=> dataReadyN [*8])
    else $error("ready fell early in main calibration");
  AST_READY_AFTER_CAL: assert property (state.st == acs_pkg::ACS_WAITDATA
    && mainSample.valid |=> !dataReadyN && idle) else $error("ready not low");
  AST_MAIN_OFF_STORE: assert property (seqStore(acs_pkg::ACS_MAIN_OFFSET_SELF_CAL_CMD)
    |=> state.mainOff == $past(accAvg[31:8])) else $error("main offset wrong");
  AST_AUX_OFF_STORE: assert property (seqStore(acs_pkg::ACS_AUX_OFFSET_SYSTEM_CAL_CMD)
    |=> state.auxOff == $past(accAvg[23:8])) else $error("aux offset wrong");
  AST_AUX_NO_READY: assert property (seqStore(acs_pkg::ACS_AUX_GAIN_SYSTEM_CAL_CMD)
    |=> idle) else $error("aux calibration waited for ready");
  AST_SHORT_SELF: assert property (cmdGo && newCmd == acs_pkg::ACS_MAIN_OFFSET_SELF_CAL_CMD
    |=> mainShortInputs [*4]) else $error("inputs not shorted");
  AST_LOCKED: assert property (!idle && avs_write && state.ack
    && idx == `ACS_IDX_MAIN_GAIN0 |=> $stable(state.mainGain[7:0]))
    else $error("coefficient written during calibration");
  AST_CHOP_NO_OFFSET: assert property (state.chop && mainSample.valid
    && state.mainGain == 24'h40_0000 |=> mainResult == $past(mainSample.data))
    else $error("offset applied in chop mode");
  AST_BUS_ONE_WAIT: assert property ($rose(avs_read) && !state.ack
    |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
endmodule
`default_nettype wire

// ===== tb/acs_conv_src.sv
// conversion source model feeding main and aux sample strobes
`default_nettype none
module acs_conv_src (
  input wire logic clk,
  input wire logic nrst,
  input wire logic runMain,
  input wire logic runAux,
  input wire logic [31:0] mainVal,
  input wire logic [23:0] auxVal,
  output acs_pkg::acs_sample_t mainSample,
  output acs_pkg::acs_sample_t auxSample
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  logic tick;
  // one conversion every fourth clock
  assign tick = (div == 2'h3);
  // ==========================================
  // sample strobes; data lines scramble between strobes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div <= 2'h0;
      mainSample <= '0;
      auxSample <= '0;
    end else begin
      div <= div + 2'h1;
      mainSample.valid <= runMain && tick;
      mainSample.data <= (runMain && tick) ? mainVal : ~mainSample.data;
      auxSample.valid <= runAux && tick;
      auxSample.data <= (runAux && tick) ? {8'h00, auxVal} : ~auxSample.data;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the calibration sequencer
`include "acs_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(what, exp, got) begin testsRun++; if ((got) !== (exp)) begin errCount++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
  logic clk, nrst, avsRead, avsWrite, runMain, runAux;
  logic dataReadyN, mainShortInputs, auxShortInputs, calBusy, avsWaitrequest;
  logic [7:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, mainResult, mainVal;
  logic [23:0] auxResult, auxVal, w;
  acs_pkg::acs_sample_t mainSample, auxSample;
  int errCount = 0;
  int testsRun = 0;
  int cyc = 0;
  // correction table: gain, chop, filter word, corrected word
  logic [23:0] gt[5] = '{24'h43_3333, 24'h3C_CCCC, 24'h3C_CCCC, 24'hFF_FFFF, 24'h40_0000};
  logic [7:0] ct[5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
  logic [31:0] dt[5] = '{32'h1000_1000, 32'h1000_1000, 32'h1000_1000, 32'h7FFF_0000,
    32'h1000_1000};
  logic [31:0] rt[5] = '{32'h10CC_CCC0, 32'h0F33_3300, 32'h0F33_4233, 32'h7FFF_FFFF,
    32'h1000_1000};
  // calibration table: code, channel, input, coefficient index, bytes, coefficient
  logic [7:0] cc[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
  logic cm[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [31:0] cv[6] = '{32'h0000_1200, 32'h0000_3400, 32'h0000_1200, 32'h0000_3400,
    32'h4000_3400, 32'h0020_3400};
  logic [5:0] cb[6] = '{6'h07, 6'h07, 6'h17, 6'h17, 6'h0a, 6'h19};
  int cn[6] = '{3, 3, 2, 2, 3, 2};
  logic [23:0] ce[6] = '{24'h00_0012, 24'h00_0034, 24'h00_0012, 24'h00_0034, 24'h7F_FFFF,
    24'h00_FFFF};

  acs_cal_seq u_acs_cal_seq (.clk(clk), .nrst(nrst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(4'h1), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .mainSample(mainSample), .auxSample(auxSample), .dataReadyN(dataReadyN),
    .mainShortInputs(mainShortInputs), .auxShortInputs(auxShortInputs), .calBusy(calBusy),
    .mainResult(mainResult), .auxResult(auxResult));
  acs_conv_src u_acs_conv_src (.clk(clk), .nrst(nrst), .runMain(runMain), .runAux(runAux),
    .mainVal(mainVal), .auxVal(auxVal), .mainSample(mainSample), .auxSample(auxSample));

  // ==========================================
  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic we, input logic [5:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avsRead <= !we;
    avsWrite <= we;
    avsAddress <= {idx, 2'b00};
    avsWritedata <= {24'h00_0000, wd};
    @(negedge clk);
    while (avsWaitrequest !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      errCount++;
      testDone();
    end
    @(posedge clk);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  // multibyte word, low byte first
  task automatic wrw(input logic [5:0] idx, input int nb, input logic [23:0] v);
    logic [31:0] d;
    for (int b = 0; b < nb; b++) acc(1'b1, idx + 6'(b), v[8*b +: 8], d);
  endtask
  task automatic rdw(input logic [5:0] idx, input int nb, output logic [23:0] v);
    logic [31:0] d;
    v = 24'h00_0000;
    for (int b = 0; b < nb; b++) begin
      acc(1'b0, idx + 6'(b), 8'h00, d);
      v[8*b +: 8] = d[7:0];
    end
  endtask

  // verdict and end of run
  task automatic testDone();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hung wait
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    testDone();
  end

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d;
    int t0;
    int n;
    nrst = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 8'h00;
    avsWritedata = 32'h0000_0000;
    runMain = 1'b0;
    runAux = 1'b0;
    mainVal = 32'h0000_0000;
    auxVal = 24'h00_0000;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // reset values and an unmapped place
    rdw(6'h0a, 3, w);
    `CHK("main gain reset", 24'h40_0000, w)
    rdw(6'h19, 2, w);
    `CHK("aux gain reset", 24'h00_4000, w)
    rdw(6'h3f, 1, w);
    `CHK("unmapped read", 24'h00_0000, w)
    wrw(6'h19, 2, 24'h00_4321);
    rdw(6'h19, 2, w);
    `CHK("aux gain readback", 24'h00_4321, w)
    $display("test registers done");
    // output correction with offset 10h, gains and chop from the table
    wrw(6'h07, 3, 24'h00_0010);
    runMain <= 1'b1;
    runAux <= 1'b1;
    auxVal <= 24'h00_4000;
    for (int i = 0; i < 5; i++) begin
      wrw(6'h0a, 3, gt[i]);
      acc(1'b1, `ACS_IDX_CTRL, ct[i], d);
      mainVal <= dt[i];
      rdw(6'h0a, 3, w);
      `CHK("gain readback", gt[i], w)
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK("main result", rt[i], mainResult)
    end
    `CHK("aux result", 24'h00_4321, auxResult)
    acc(1'b1, `ACS_IDX_CTRL, 8'h00, d);
    $display("test correction done");
    // commands, offsets before gains, each on a settled running input
    for (int k = 0; k < 6; k++) begin
      runMain <= cm[k];
      runAux <= !cm[k];
      mainVal <= cv[k];
      auxVal <= cv[k][23:0];
      repeat (12) @(posedge clk);
      acc(1'b0, `ACS_IDX_RESULT, 8'h00, d);
      acc(1'b1, `ACS_IDX_CMD, cc[k], d);
      t0 = cyc;
      repeat (3) @(negedge clk);
      `CHK("busy", 1'b1, calBusy)
      `CHK("ready during cal", 1'b1, dataReadyN)
      `CHK("main short", cc[k] == 8'h01, mainShortInputs)
      `CHK("aux short", cc[k] == 8'h03, auxShortInputs)
      wrw(cb[k], cn[k], 24'h55_5555);
      n = 0;
      while (calBusy !== 1'b0 && n < 1000) begin
        @(negedge clk);
        n++;
      end
      `CHK("cal length", 1'b1, (cyc - t0 >= 58) && (cyc - t0 <= 76))
      `CHK("ready after cal", !cm[k], dataReadyN)
      rdw(cb[k], cn[k], w);
      `CHK("coefficient", ce[k], w)
      acc(1'b0, `ACS_IDX_STATUS, 8'h00, d);
      `CHK("status", 32'({!cm[k], 1'b0, cc[k][2:0]}), d)
      $display("test command %0d done", cc[k]);
    end
    testDone();
  end
endmodule
`default_nettype wire
